// ### rtl/ssw_pkg.sv
// package: timing constants and state codes for the supply supervisor watchdog
package ssw_pkg;
  localparam int unsigned SSW_CLK_HZ = 100_000_000; // system clock rate
  localparam int unsigned SSW_PULSE_MS = 200; // nominal reset pulse, ms
  localparam int unsigned SSW_STRETCH_MIN_MS = 140; // least extension after a supply dip, ms
  localparam int unsigned SSW_TIMEOUT_MS = 1600; // nominal watchdog timeout, ms
  localparam int unsigned SSW_STROBE_MIN_NS = 50; // shortest strobe pulse to detect, ns
  localparam int unsigned SSW_CLK_PERIOD_NS = 1_000_000_000 / SSW_CLK_HZ; // clock period, ns
  // cycle counts derived from the times above
  localparam int unsigned SSW_PULSE_CYC = SSW_PULSE_MS * (SSW_CLK_HZ / 1000);
  localparam int unsigned SSW_STRETCH_MIN_CYC = SSW_STRETCH_MIN_MS * (SSW_CLK_HZ / 1000);
  localparam int unsigned SSW_TIMEOUT_CYC = SSW_TIMEOUT_MS * (SSW_CLK_HZ / 1000);
  // strobe pulses shorter than this many clocks may be missed (least time, rounded up)
  localparam int unsigned SSW_STROBE_MIN_CYC = (SSW_STROBE_MIN_NS + SSW_CLK_PERIOD_NS - 1) / SSW_CLK_PERIOD_NS;
  localparam int unsigned SSW_CNT_W = 32; // width of the duration counters
  localparam logic [1:0] SSW_SYNC_RST = 2'h0; // synchroniser reset value
  // reset-pulse controller states
  typedef enum logic [1:0] {
    SSW_ST_HOLD = 2'b00, // supply low or manual reset held: reset asserted, no count
    SSW_ST_STRETCH = 2'b01, // counting down the pulse
    SSW_ST_RUN = 2'b10 // reset released
  } ssw_state_type;
endpackage

// ### rtl/ssw_supervisor.sv
// module: supply supervisor with reset stretcher, watchdog and power-fail warning
`timescale 1ns/100ps
// How it works
// - manual reset low starts reset pulse
// - warning low while sense below reference
// - steady strobe for timeout drives expiry low
// - floating strobe disables the watchdog
// - each reset holds output low full pulse
// - reset low while supply is low
// - full pulse after supply/manual release
// - watchdog expiry never asserts reset itself
// - expiry output stays low until cleared
// - supply low forces expiry output low
// - expiry output releases immediately, no stretch
// - active-high reset is exact inverse
// - dip mid-pulse extends at least minimum
// - timer counts after release when driven
// - detect short strobe pulses; host toggles
module ssw_supervisor
  import ssw_pkg::*;
#(
  parameter int unsigned PULSE_CYC = SSW_PULSE_CYC, // reset pulse length, cycles
  parameter int unsigned STRETCH_MIN_CYC = SSW_STRETCH_MIN_CYC, // least extension after a dip
  parameter int unsigned TIMEOUT_CYC = SSW_TIMEOUT_CYC // watchdog timeout, cycles
) (
  input wire logic clk_sys_i, // system clock, 100 MHz
  input wire logic resetn_i, // async reset, active low
  input wire logic supply_low_i, // supply below reset threshold
  input wire logic manual_reset_n_i, // manual reset, active low
  input wire logic power_fail_sense_in_i, // high when monitored voltage above reference
  input wire logic watchdog_strobe_in_i, // watchdog strobe level from host
  input wire logic strobe_float_i, // high while the strobe is undriven
  output logic reset_n_o, // active-low reset to host
  output logic reset_o, // active-high reset to host
  output logic power_fail_warn_n_o, // power-fail warning, active low
  output logic watchdog_expired_n_o // watchdog expired or low line, active low
);
  ssw_sync_if sif(); // synchronised levels
  logic [4:0] sync_w; // synchroniser output bundle
  ssw_state_type state_q; // reset controller state
  ssw_state_type state_d; // next state
  logic [SSW_CNT_W-1:0] pulse_cnt_q; // cycles left in the reset pulse
  logic [SSW_CNT_W-1:0] pulse_cnt_d; // next pulse count
  logic [SSW_CNT_W-1:0] wd_cnt_q; // watchdog elapsed cycles
  logic [SSW_CNT_W-1:0] wd_cnt_d; // next watchdog count
  logic strobe_prev_q; // strobe level one cycle back
  logic wd_done_q; // timer has expired
  logic wd_done_d; // next expiry flag
  logic reset_n_q; // registered reset output
  logic pfw_n_q; // registered warning output
  logic trigger_w; // something holds reset
  logic supply_rise_w; // supply low appeared this cycle
  logic strobe_edge_w; // strobe toggled
  logic wd_clear_w; // watchdog clear condition
  logic [SSW_CNT_W-1:0] stretch_w; // minimum remaining after a dip

  // all inputs except clk_sys_i and resetn_i pass two flops before any use
  ssw_sync #(.WIDTH(5)) u_sync (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .raw_i({supply_low_i, manual_reset_n_i, power_fail_sense_in_i, watchdog_strobe_in_i, strobe_float_i}),
    .sync_o(sync_w)
  );
  assign sif.supply_low = sync_w[4];
  assign sif.manual_reset_n = sync_w[3];
  assign sif.power_fail_sense_in = sync_w[2];
  assign sif.watchdog_strobe_in = sync_w[1];
  assign sif.strobe_float = sync_w[0];

  // decode of triggers; the watchdog expiry is deliberately not a term here
  assign trigger_w = sif.supply_low | ~sif.manual_reset_n;
  logic supply_low_prev_q; // supply low one cycle back, for dip detection
  assign supply_rise_w = sif.supply_low & ~supply_low_prev_q;
  assign stretch_w = SSW_CNT_W'(STRETCH_MIN_CYC);

  // reset controller: hold while triggered, then count the full pulse
  always_comb begin
    state_d = state_q;
    pulse_cnt_d = pulse_cnt_q;
    case (state_q)
      SSW_ST_HOLD: begin
        if (!trigger_w) begin
          state_d = SSW_ST_STRETCH;
          pulse_cnt_d = SSW_CNT_W'(PULSE_CYC);
        end
      end
      SSW_ST_STRETCH: begin
        if (trigger_w) begin
          state_d = SSW_ST_HOLD; // new trigger restarts the pulse after release
        end else if (pulse_cnt_q <= SSW_CNT_W'(1)) begin
          state_d = SSW_ST_RUN;
          pulse_cnt_d = '0;
        end else begin
          pulse_cnt_d = pulse_cnt_q - SSW_CNT_W'(1);
        end
      end
      SSW_ST_RUN: begin
        if (trigger_w) begin
          state_d = SSW_ST_HOLD;
        end
      end
      default: begin
        state_d = SSW_ST_HOLD;
      end
    endcase
  end
  // a dip mid-pulse holds, and the release then reloads a full pulse, which exceeds the minimum
  wire dip_in_pulse_w = supply_rise_w & (state_q == SSW_ST_STRETCH);
  wire reset_asserted_w = (state_d != SSW_ST_RUN);

  // watchdog: clear on reset, float or any strobe edge; count otherwise
  assign strobe_edge_w = sif.watchdog_strobe_in ^ strobe_prev_q;
  assign wd_clear_w = reset_asserted_w | sif.strobe_float | strobe_edge_w;
  always_comb begin
    wd_cnt_d = wd_cnt_q;
    wd_done_d = wd_done_q;
    if (wd_clear_w) begin
      wd_cnt_d = '0;
      wd_done_d = 1'b0;
    end else if (wd_cnt_q >= SSW_CNT_W'(TIMEOUT_CYC - 1)) begin
      wd_done_d = 1'b1;
    end else begin
      wd_cnt_d = wd_cnt_q + SSW_CNT_W'(1);
    end
  end

  // state and counters
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= SSW_ST_HOLD;
      pulse_cnt_q <= '0;
      wd_cnt_q <= '0;
      wd_done_q <= 1'b0;
      strobe_prev_q <= 1'b0;
      supply_low_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pulse_cnt_q <= dip_in_pulse_w && (pulse_cnt_d < stretch_w) ? stretch_w : pulse_cnt_d;
      wd_cnt_q <= wd_cnt_d;
      wd_done_q <= wd_done_d;
      strobe_prev_q <= sif.watchdog_strobe_in;
      supply_low_prev_q <= sif.supply_low;
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reset_n_q <= 1'b0;
      pfw_n_q <= 1'b0;
    end else begin
      reset_n_q <= ~reset_asserted_w;
      pfw_n_q <= sif.power_fail_sense_in;
    end
  end

  assign reset_n_o = reset_n_q;
  assign reset_o = ~reset_n_q;
  assign power_fail_warn_n_o = pfw_n_q;
  // low line forces it low and releases with no stretch
  assign watchdog_expired_n_o = ~(wd_done_q | sif.supply_low);

  // assertions
  property p_inverse;
    @(posedge clk_sys_i) disable iff (!resetn_i) reset_o == ~reset_n_o;
  endproperty
  a_inverse: assert property (p_inverse) else $error("reset outputs not complementary");

  property p_supply_holds;
    @(posedge clk_sys_i) disable iff (!resetn_i) sif.supply_low |=> !reset_n_o;
  endproperty
  a_supply_holds: assert property (p_supply_holds) else $error("reset released during supply low");

  property p_manual;
    @(posedge clk_sys_i) disable iff (!resetn_i) !sif.manual_reset_n |=> !reset_n_o;
  endproperty
  a_manual: assert property (p_manual) else $error("manual reset did not assert reset");

  property p_pulse_min;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (state_q == SSW_ST_HOLD && !trigger_w) |=> !reset_n_o [*2];
  endproperty
  a_pulse_min: assert property (p_pulse_min) else $error("reset released too early");

  property p_wd_low_line;
    @(posedge clk_sys_i) disable iff (!resetn_i) sif.supply_low |-> !watchdog_expired_n_o;
  endproperty
  a_wd_low_line: assert property (p_wd_low_line) else $error("expiry output high in low line");

  // keyed to the reset decision itself: the registered reset output lags it by one edge,
  // so at the release edge the timer has already started its first count
  property p_wd_clear;
    @(posedge clk_sys_i) disable iff (!resetn_i) (sif.strobe_float || reset_asserted_w) |=> wd_cnt_q == '0;
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("watchdog not cleared");

  property p_wd_no_reset;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (wd_done_q && !trigger_w && state_q == SSW_ST_RUN) |=> reset_n_o;
  endproperty
  a_wd_no_reset: assert property (p_wd_no_reset) else $error("expiry asserted reset");

  property p_pfw;
    @(posedge clk_sys_i) disable iff (!resetn_i) 1'b1 |=> power_fail_warn_n_o == $past(sif.power_fail_sense_in);
  endproperty
  a_pfw: assert property (p_pfw) else $error("warning does not follow sense");

  property p_wd_sticky;
    @(posedge clk_sys_i) disable iff (!resetn_i) (wd_done_q && !wd_clear_w) |=> wd_done_q;
  endproperty
  a_wd_sticky: assert property (p_wd_sticky) else $error("expiry dropped without clear");

  // a dip mid-pulse must keep reset low well past the dip, never release it soon after
  property p_dip_extends;
    @(posedge clk_sys_i) disable iff (!resetn_i) dip_in_pulse_w |=> !reset_n_o [*8];
  endproperty
  a_dip_extends: assert property (p_dip_extends) else $error("reset not extended after dip");

  // once the low line clears, an unexpired watchdog lets its output go at once
  property p_wd_no_stretch;
    @(posedge clk_sys_i) disable iff (!resetn_i) ($fell(sif.supply_low) && !wd_done_q) |-> watchdog_expired_n_o;
  endproperty
  a_wd_no_stretch: assert property (p_wd_no_stretch) else $error("expiry output held after low line");

  c_expire: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) $rose(wd_done_q));
  c_release: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) $rose(reset_n_o));
  c_dip: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) dip_in_pulse_w);
  c_float: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) sif.strobe_float && !wd_done_q);
endmodule

// ### rtl/ssw_sync.sv
// module: two-flop synchronisers for the supervisor's digital inputs
`timescale 1ns/100ps
module ssw_sync
  import ssw_pkg::*;
#(
  parameter int unsigned WIDTH = 5 // number of levels synchronised
) (
  input wire logic clk_sys_i, // system clock
  input wire logic resetn_i, // async reset, active low
  input wire logic [WIDTH-1:0] raw_i, // raw levels
  output logic [WIDTH-1:0] sync_o // synchronised levels
);
  logic [WIDTH-1:0] meta_q; // first stage, read only by the second
  logic [WIDTH-1:0] sync_q; // second stage

  // first stage: resets low; the core treats the first two cycles as idle anyway
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= '0;
    end else begin
      meta_q <= raw_i;
    end
  end

  // second stage
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_q <= '0;
    end else begin
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule

// ### rtl/ssw_sync_if.sv
// interface: synchronised input levels passed from the synchroniser to the core
`timescale 1ns/100ps
interface ssw_sync_if;
  logic supply_low; // supply below reset threshold
  logic manual_reset_n; // manual reset, active low
  logic power_fail_sense_in; // monitored voltage above reference
  logic watchdog_strobe_in; // strobe level
  logic strobe_float; // strobe not driven
  modport src (output supply_low, output manual_reset_n, output power_fail_sense_in,
               output watchdog_strobe_in, output strobe_float);
  modport dst (input supply_low, input manual_reset_n, input power_fail_sense_in,
               input watchdog_strobe_in, input strobe_float);
endinterface

// ### verification/ssw_host_model.sv
// host model: drives the watchdog strobe and the strobe-undriven flag
`timescale 1ns/100ps
module ssw_host_model #(
  parameter int unsigned TOGGLE_CYC = 30 // cycles between toggles, kept below the timeout
) (
  input wire logic clk_sys_i, // system clock
  input wire logic kick_i, // one strobe edge per cycle held high
  input wire logic toggle_en_i, // periodic toggling on
  input wire logic float_en_i, // strobe left undriven
  output logic strobe_o = 1'b0, // strobe level
  output logic strobe_float_o = 1'b0 // undriven flag
);
  int unsigned cnt_q = 0; // cycles since the last periodic toggle
  // changes land by non-blocking assignment on the rising edge, so no race with the bench
  always @(posedge clk_sys_i) begin
    strobe_float_o <= float_en_i;
    cnt_q <= (toggle_en_i && cnt_q < TOGGLE_CYC - 1) ? cnt_q + 1 : 0;
    if (float_en_i && !strobe_float_o) begin
      strobe_o <= ~strobe_o; // a released line drifts once and then sits, so no edge keeps the timer clear
    end else if (!float_en_i && (kick_i || (toggle_en_i && cnt_q == TOGGLE_CYC - 1))) begin
      strobe_o <= ~strobe_o;
    end
  end
endmodule

// ### verification/tb_top.sv
// testbench: directed scenarios for the supply supervisor watchdog
`timescale 1ns/100ps
module tb_top;
  import ssw_pkg::*;
  localparam int unsigned PC = 20; // shortened reset pulse, cycles
  localparam int unsigned SC = 14; // shortened least extension, cycles
  localparam int unsigned TC = 50; // shortened watchdog timeout, cycles
  logic clk_sys_i = 1'b0; // system clock
  logic resetn_i = 1'b0; // async reset, active low
  logic supply_low = 1'b0; // supply below threshold
  logic manual_reset_n = 1'b1; // manual reset, active low
  logic sense = 1'b1; // monitored voltage above reference
  logic kick = 1'b0; // request one strobe edge
  logic toggle_en = 1'b0; // host toggles periodically
  logic float_en = 1'b0; // host leaves strobe undriven
  logic strobe; // strobe from host model
  logic strobe_float; // undriven flag from host model
  logic reset_n; // active-low reset out
  logic reset_h; // active-high reset out
  logic warn_n; // power-fail warning
  logic expired_n; // watchdog expiry
  int failures = 0; // mismatches
  int checks = 0; // comparisons
  int cycles = 0; // timeout counter
  ssw_supervisor #(.PULSE_CYC(PC), .STRETCH_MIN_CYC(SC), .TIMEOUT_CYC(TC)) uut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .supply_low_i(supply_low),
    .manual_reset_n_i(manual_reset_n), .power_fail_sense_in_i(sense),
    .watchdog_strobe_in_i(strobe), .strobe_float_i(strobe_float), .reset_n_o(reset_n),
    .reset_o(reset_h), .power_fail_warn_n_o(warn_n), .watchdog_expired_n_o(expired_n));
  ssw_host_model host (.clk_sys_i(clk_sys_i), .kick_i(kick), .toggle_en_i(toggle_en),
    .float_en_i(float_en), .strobe_o(strobe), .strobe_float_o(strobe_float));
  // free-running clock, 10 ns period
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // hang guard: the whole run needs about eight hundred cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end
  task automatic conclude(); // report counts and verdict
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic seen, input logic exp); // four-state compare
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n); // step falling edges
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic wait_lvl(input bit wd, input logic v, input int max); // bounded wait, then compare
    for (int i = 0; i < max && ((wd ? expired_n : reset_n) !== v); i++) cyc(1);
    chk(wd ? expired_n : reset_n, v);
  endtask
  task automatic strobe_edge(); // one strobe edge from the host
    kick = 1'b1;
    cyc(1);
    kick = 1'b0;
  endtask
  task automatic t_power_up(); // pulse after reset release
    chk(reset_n, 1'b0);
    chk(reset_h, 1'b1);
    chk(expired_n, 1'b1);
    resetn_i = 1'b1;
    cyc(PC - 2);
    chk(reset_n, 1'b0);
    wait_lvl(0, 1'b1, 12);
    chk(reset_h, 1'b0);
  endtask
  task automatic t_power_fail(); // warning follows the sense level, no reset
    sense = 1'b0;
    cyc(5);
    chk(warn_n, 1'b0);
    chk(reset_n, 1'b1);
    sense = 1'b1;
    cyc(5);
    chk(warn_n, 1'b1);
  endtask
  task automatic t_watchdog(); // expiry, latch, clear, kept alive
    strobe_edge();
    cyc(TC - 3);
    chk(expired_n, 1'b1);
    wait_lvl(1, 1'b0, 12);
    cyc(TC + 20);
    chk(expired_n, 1'b0);
    chk(reset_n, 1'b1);
    strobe_edge();
    wait_lvl(1, 1'b1, 6);
    toggle_en = 1'b1;
    cyc(4 * TC);
    chk(expired_n, 1'b1);
    toggle_en = 1'b0;
  endtask
  task automatic t_float(); // undriven strobe halts the timer, driven restarts it
    float_en = 1'b1;
    cyc(3 * TC);
    chk(expired_n, 1'b1);
    float_en = 1'b0;
    cyc(TC - 3);
    chk(expired_n, 1'b1);
    wait_lvl(1, 1'b0, 12);
    strobe_edge();
    wait_lvl(1, 1'b1, 6);
  endtask
  task automatic t_manual(); // held manual reset, timer cleared meanwhile
    manual_reset_n = 1'b0;
    cyc(5);
    chk(reset_n, 1'b0);
    chk(reset_h, 1'b1);
    cyc(TC + 10);
    chk(expired_n, 1'b1);
    manual_reset_n = 1'b1;
    cyc(PC - 1);
    chk(reset_n, 1'b0);
    wait_lvl(0, 1'b1, 12);
    strobe_edge();
  endtask
  task automatic t_supply(); // supply low forces both outputs, expiry has no stretch
    supply_low = 1'b1;
    cyc(4);
    chk(expired_n, 1'b0);
    cyc(TC);
    chk(reset_n, 1'b0);
    supply_low = 1'b0;
    cyc(4);
    chk(expired_n, 1'b1);
    cyc(PC - 5);
    chk(reset_n, 1'b0);
    wait_lvl(0, 1'b1, 12);
    strobe_edge();
  endtask
  task automatic t_dip(); // short dip in the middle of a pulse extends it
    manual_reset_n = 1'b0;
    cyc(5);
    manual_reset_n = 1'b1;
    cyc(8);
    supply_low = 1'b1;
    cyc(2);
    supply_low = 1'b0;
    cyc(SC);
    chk(reset_n, 1'b0);
    wait_lvl(0, 1'b1, PC + 12);
  endtask
  // main sequence: reset held 16 cycles, then every scenario in turn
  initial begin
    cyc(16);
    t_power_up();
    t_power_fail();
    t_watchdog();
    t_float();
    t_manual();
    t_supply();
    t_dip();
    conclude();
  end
endmodule
